// >>> acc_params.svh
// Register map, field positions and reset values of the calibration register bank
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register indices; byte address is four times the index
`define ACC_IDX_EN      8'h61
`define ACC_IDX_CFG0    8'h62
`define ACC_IDX_CFG1    8'h65
`define ACC_IDX_AVG     8'h68
`define ACC_IDX_STAT    8'h6a
`define ACC_IDX_PIN     8'h6b
`define ACC_IDX_TRIG    8'h6c

// Reset values
`define ACC_RST_EN      8'h01
`define ACC_RST_CFG0    8'h01
`define ACC_RST_CFG1    8'h01
`define ACC_RST_AVG     8'h61
`define ACC_RST_PIN     8'h00
`define ACC_RST_TRIG    8'h01

// Field positions
`define ACC_B_RUN       0
`define ACC_B_FG        0
`define ACC_B_BG        1
`define ACC_B_FOS       2
`define ACC_B_BOS       3
`define ACC_B_OFFSET_REFERENCE_SELECT     2
`define ACC_F_OSAVG     6:4
`define ACC_F_LINAVG    2:0
`define ACC_B_TSRC      0
`define ACC_F_SSEL      2:1
`define ACC_B_STRIG     0

// Status-output select codes
`define ACC_SSEL_FG     2'h0
`define ACC_SSEL_STOP   2'h1
`define ACC_SSEL_ALARM  2'h2
`define ACC_SSEL_LOW    2'h3

`endif

// >>> acc_pkg.sv
// Types shared by the calibration register bank and its sequencer
package acc_pkg;
	typedef enum logic [2:0] {st_hold, st_clear, st_fg, st_bg, st_done} acc_state_t;
	typedef logic [2:0] acc_code_t;
	typedef logic [7:0] acc_byte_t;
endpackage

// >>> acc_seq.sv
// Calibration sequencer: clear, foreground run, background run and halt flags
`timescale 1ns/100ps
`default_nettype none
module acc_seq
	import acc_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	input  wire logic       run_en_i,
	input  wire logic       fg_en_i,
	input  wire logic       bg_en_i,
	input  wire logic       trig_i,
	input  wire logic       fg_finished_i,
	input  wire logic       bg_halted_i,
	output var  acc_pkg::acc_state_t state_o,
	output var  acc_pkg::acc_code_t  code_o,
	output logic            clear_o,
	output logic            fg_start_o,
	output logic            bg_run_o,
	output logic            foreground_complete_flag_o,
	output logic            stopped_o
);
	import acc_pkg::*;

	acc_state_t state_q;

	// Sequence; a low master enable holds everything in reset
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || !run_en_i)
			state_q <= st_hold;
		else
			case (state_q)
				st_hold:  state_q <= st_clear;
				st_clear: state_q <= fg_en_i ? st_fg : (bg_en_i ? st_bg : st_done);
				st_fg:    if (fg_finished_i) state_q <= bg_en_i ? st_bg : st_done;
				default:  state_q <= state_q;
			endcase
	end

	// Clear pulse and foreground start pulse; values are cleared whether or not it runs
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			clear_o    <= 1'b0;
			fg_start_o <= 1'b0;
		end
		else
		begin
			clear_o    <= run_en_i && state_q == st_hold;
			fg_start_o <= run_en_i && state_q == st_clear && fg_en_i;
		end
	end

	// Foreground done covers both finish and skip
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || !run_en_i)
			foreground_complete_flag_o <= 1'b0;
		else if ((state_q == st_clear && !fg_en_i) || (state_q == st_fg && fg_finished_i))
			foreground_complete_flag_o <= 1'b1;
	end

	// Background runs while the trigger is high; halt is acknowledged by the core
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || !run_en_i)
			bg_run_o <= 1'b0;
		else
			bg_run_o <= state_q == st_bg && bg_en_i && trig_i;
	end

	// Stopped flag; with no background the end of the foreground phase sets it
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || !run_en_i)
			stopped_o <= 1'b0;
		else if (state_q == st_bg && !trig_i && bg_halted_i)
			stopped_o <= 1'b1;
		else if (state_q == st_bg && trig_i)
			stopped_o <= 1'b0;
		else if (state_q != st_done && !bg_en_i &&
			((state_q == st_clear && !fg_en_i) || (state_q == st_fg && fg_finished_i)))
			stopped_o <= 1'b1;
	end

	assign state_o = state_q;
	assign code_o  = acc_code_t'(state_q);
endmodule
`default_nettype wire

// >>> acc_regs.sv
// Calibration configuration and status register bank with Wishbone slave
// Summary of operation
// - Foreground run bit resets one; clears, runs
// - Background enable resets zero, enables background
// - Reference zero: offset targets mid-code
// - Reference one: match spare converter output
// - Offset averaging field bits 6:4, reset 6
// - Linearity averaging field bits 2:0, reset 1
// - Status register read-only: code, stopped, done
// - Stopped flag sets when background halts
// - Stopped flag clears when calibration resumes
// - No background: stopped after foreground ends
// - Done flag high after finish or skip
// - Pin setup resets zero: trigger, status select
// - Status select: done, stopped, alarm, low
// - Trigger source picks pin or software bit
// - Master enable runs or holds calibration
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "acc_params.svh"
module acc_regs
	import acc_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        hardware_trigger_pin_i,
	input  wire logic        alarm_i,
	input  wire logic        fg_finished_i,
	input  wire logic        bg_halted_i,
	output logic             status_output_pin_o,
	output logic             clear_values_o,
	output logic             fg_start_o,
	output logic             bg_run_o,
	output logic             foreground_offset_enable_o,
	output logic             background_offset_enable_o,
	output logic             offset_reference_select_o,
	output logic [2:0]       offset_averaging_depth_o,
	output logic [2:0]       linearity_averaging_depth_o
);
	import acc_pkg::*;

	acc_byte_t  en_q;
	acc_byte_t  cfg0_q;
	acc_byte_t  cfg1_q;
	acc_byte_t  avg_q;
	acc_byte_t  pin_q;
	acc_byte_t  strig_q;
	acc_byte_t  rd_d;
	logic [31:0] dat_q;
	logic       ack_q;
	logic       trig_q;
	logic       pin_out_q;
	logic       snap_fg_q;
	logic       snap_bg_q;
	logic       snap_fos_q;
	logic       snap_bos_q;
	logic       snap_ref_q;
	logic [2:0] snap_osavg_q;
	logic [2:0] snap_linavg_q;
	logic       wr_en;
	logic [7:0] idx;
	acc_state_t seq_state;
	acc_code_t  seq_code;
	logic       foreground_complete_flag;
	logic       stopped;

	// Bus request decode; byte lane 0 carries every register
	assign idx   = wb_adr_i[9:2];
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];

	// Single-wait-state acknowledge, dropped the cycle after it is given
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			ack_q <= 1'b0;
		else
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
	end

	// Master enable; low holds the sequencer and unfreezes the snapshot
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			en_q <= `ACC_RST_EN;
		else if (wr_en && idx == `ACC_IDX_EN)
			en_q <= wb_dat_i[7:0];
	end

	// Main configuration; reserved bits kept as written
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			cfg0_q <= `ACC_RST_CFG0;
		else if (wr_en && idx == `ACC_IDX_CFG0)
			cfg0_q <= wb_dat_i[7:0];
	end

	// Offset reference configuration
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			cfg1_q <= `ACC_RST_CFG1;
		else if (wr_en && idx == `ACC_IDX_CFG1)
			cfg1_q <= wb_dat_i[7:0];
	end

	// Averaging depths
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			avg_q <= `ACC_RST_AVG;
		else if (wr_en && idx == `ACC_IDX_AVG)
			avg_q <= wb_dat_i[7:0];
	end

	// Pin setup: trigger source and status-output select
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			pin_q <= `ACC_RST_PIN;
		else if (wr_en && idx == `ACC_IDX_PIN)
			pin_q <= wb_dat_i[7:0];
	end

	// Software trigger; its default high means no trigger is needed
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			strig_q <= `ACC_RST_TRIG;
		else if (wr_en && idx == `ACC_IDX_TRIG)
			strig_q <= wb_dat_i[7:0];
	end

	// Read mux; unmapped addresses read zero, status ignores writes
	always_comb
	begin
		rd_d = 8'h00;
		if (idx == `ACC_IDX_EN)
			rd_d = en_q;
		else if (idx == `ACC_IDX_CFG0)
			rd_d = cfg0_q;
		else if (idx == `ACC_IDX_CFG1)
			rd_d = cfg1_q;
		else if (idx == `ACC_IDX_AVG)
			rd_d = avg_q;
		else if (idx == `ACC_IDX_STAT)
			rd_d = {3'h0, seq_code, stopped, foreground_complete_flag};
		else if (idx == `ACC_IDX_PIN)
			rd_d = pin_q;
		else if (idx == `ACC_IDX_TRIG)
			rd_d = strig_q;
	end

	// Read data registered with the acknowledge
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			dat_q <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !ack_q)
			dat_q <= {24'h00_0000, rd_d};
	end

	// Settings only move while the master enable is low, so a run never sees them change
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			snap_fg_q     <= 1'b1;
			snap_bg_q     <= 1'b0;
			snap_fos_q    <= 1'b0;
			snap_bos_q    <= 1'b0;
			snap_ref_q    <= 1'b0;
			snap_osavg_q  <= 3'h6;
			snap_linavg_q <= 3'h1;
		end
		else if (!en_q[`ACC_B_RUN])
		begin
			snap_fg_q     <= cfg0_q[`ACC_B_FG];
			snap_bg_q     <= cfg0_q[`ACC_B_BG];
			// Offset steps have no effect without their parent calibration
			snap_fos_q    <= cfg0_q[`ACC_B_FOS] && cfg0_q[`ACC_B_FG];
			snap_bos_q    <= cfg0_q[`ACC_B_BOS] && cfg0_q[`ACC_B_BG];
			// Spare reference is undefined without background; passed through as set
			snap_ref_q    <= cfg1_q[`ACC_B_OFFSET_REFERENCE_SELECT];
			snap_osavg_q  <= avg_q[`ACC_F_OSAVG];
			snap_linavg_q <= avg_q[`ACC_F_LINAVG];
		end
	end

	// Trigger source: the unused source is ignored entirely
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			trig_q <= 1'b1;
		else if (pin_q[`ACC_B_TSRC])
			trig_q <= hardware_trigger_pin_i;
		else
			trig_q <= strig_q[`ACC_B_STRIG];
	end

	// Status pin routing
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			pin_out_q <= 1'b0;
		else
			case (pin_q[`ACC_F_SSEL])
				`ACC_SSEL_FG:    pin_out_q <= foreground_complete_flag;
				`ACC_SSEL_STOP:  pin_out_q <= stopped;
				`ACC_SSEL_ALARM: pin_out_q <= alarm_i;
				default:         pin_out_q <= 1'b0;
			endcase
	end

	// Sequencer takes its run enables from the snapshot; master enable and trigger come from live registers
	acc_seq u_seq (
		.core_clk_i    (core_clk_i),
		.srst_i        (srst_i),
		.run_en_i      (en_q[`ACC_B_RUN]),
		.fg_en_i       (snap_fg_q),
		.bg_en_i       (snap_bg_q),
		.trig_i        (trig_q),
		.fg_finished_i (fg_finished_i),
		.bg_halted_i   (bg_halted_i),
		.state_o       (seq_state),
		.code_o        (seq_code),
		.clear_o       (clear_values_o),
		.fg_start_o    (fg_start_o),
		.bg_run_o      (bg_run_o),
		.foreground_complete_flag_o     (foreground_complete_flag),
		.stopped_o     (stopped)
	);

	// Outputs
	assign wb_ack_o                    = ack_q;
	assign wb_dat_o                    = dat_q;
	assign status_output_pin_o         = pin_out_q;
	assign foreground_offset_enable_o  = snap_fos_q;
	assign background_offset_enable_o  = snap_bos_q;
	assign offset_reference_select_o   = snap_ref_q;
	assign offset_averaging_depth_o    = snap_osavg_q;
	assign linearity_averaging_depth_o = snap_linavg_q;

	// Checks on the register bank and sequencer
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	AST_CFG0_RESET: assert property (disable iff (1'b0)
		srst_i |=> cfg0_q == `ACC_RST_CFG0 && avg_q == `ACC_RST_AVG)
		else $error("config reset value wrong");

	AST_PIN_RESET: assert property (disable iff (1'b0)
		srst_i |=> pin_q == `ACC_RST_PIN)
		else $error("pin setup reset value wrong");

	AST_BG_OFF: assert property (
		!snap_bg_q |-> !bg_run_o)
		else $error("background runs while disabled");

	AST_FG_SKIP: assert property (
		$rose(en_q[0]) && !snap_fg_q |-> ##2 foreground_complete_flag)
		else $error("skip did not raise done two cycles later");

	AST_FG_RUN: assert property (
		$rose(en_q[0]) && snap_fg_q |-> ##1 clear_values_o ##1 fg_start_o && !foreground_complete_flag)
		else $error("clear then start sequence broken");

	AST_STOP_NO_BG: assert property (
		$rose(foreground_complete_flag) && !snap_bg_q |-> stopped)
		else $error("stopped not set with foreground end");

	AST_STOP_SET: assert property (
		seq_state == st_bg && !trig_q && bg_halted_i |=> stopped)
		else $error("halt not flagged");

	AST_STOP_CLEAR: assert property (
		stopped && seq_state == st_bg && trig_q |=> !stopped)
		else $error("stopped not cleared on resume");

	AST_PIN_LOW: assert property (
		pin_q[2:1] == `ACC_SSEL_LOW |=> !status_output_pin_o)
		else $error("status pin not held low");

	AST_PIN_ALARM: assert property (
		pin_q[2:1] == `ACC_SSEL_ALARM |=> status_output_pin_o == $past(alarm_i))
		else $error("status pin does not follow alarm");

	AST_TRIG_HW: assert property (
		pin_q[0] |=> trig_q == $past(hardware_trigger_pin_i))
		else $error("hardware trigger not selected");

	AST_HOLD: assert property (
		!en_q[0] |=> !foreground_complete_flag && !stopped && !bg_run_o && seq_state == st_hold)
		else $error("sequencer not held in reset");

	AST_SNAP: assert property (
		en_q[0] && $past(en_q[0]) |-> $stable(snap_osavg_q) && $stable(snap_bg_q))
		else $error("settings changed during a run");

	AST_ACK: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	COV_FOREGROUND_COMPLETE_FLAG: cover property (seq_state == st_fg ##1 foreground_complete_flag);
	COV_BG_HALT: cover property (seq_state == st_bg && !stopped ##1 stopped);
	COV_ALARM:   cover property (status_output_pin_o && pin_q[2:1] == `ACC_SSEL_ALARM);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/100ps
`default_nettype none
`include "acc_params.svh"
module tb_top;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic        ack;
	logic        hw_trig = 1'b0;
	logic        alarm = 1'b0;
	logic        fg_fin = 1'b0;
	logic        bg_halt = 1'b0;
	logic        stat_pin;
	logic        clr;
	logic        fg_start;
	logic        bg_run;
	logic        fos;
	logic        bos;
	logic        oref;
	logic [2:0]  osavg;
	logic [2:0]  linavg;
	logic [31:0] q;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          n_clr = 0;
	int          n_fgs = 0;

	acc_regs dut (
		.core_clk_i                  (clk),
		.srst_i                      (srst),
		.wb_cyc_i                    (cyc),
		.wb_stb_i                    (stb),
		.wb_we_i                     (we),
		.wb_adr_i                    (adr),
		.wb_sel_i                    (sel),
		.wb_dat_i                    (dat_i),
		.wb_dat_o                    (dat_o),
		.wb_ack_o                    (ack),
		.hardware_trigger_pin_i      (hw_trig),
		.alarm_i                     (alarm),
		.fg_finished_i               (fg_fin),
		.bg_halted_i                 (bg_halt),
		.status_output_pin_o         (stat_pin),
		.clear_values_o              (clr),
		.fg_start_o                  (fg_start),
		.bg_run_o                    (bg_run),
		.foreground_offset_enable_o  (fos),
		.background_offset_enable_o  (bos),
		.offset_reference_select_o   (oref),
		.offset_averaging_depth_o    (osavg),
		.linearity_averaging_depth_o (linavg)
	);

	// 125 MHz core clock
	always #4 clk = ~clk;

	// Count clear and start pulses; single-cycle pulses are easy to miss by sampling
	always @(posedge clk)
	begin
		if (clr === 1'b1)
			n_clr++;
		if (fg_start === 1'b1)
			n_fgs++;
	end

	// Verdict and end of run
	task automatic wrap_up();
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Compare one value, case equality so unknowns never match
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Classic single Wishbone cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
			input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		dat_i <= {24'h00_0000, d};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 16);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'b1, idx, d, 4'hf, r);
	endtask

	// Read and compare the masked word
	task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, idx, 8'h00, 4'hf, r);
		chk(r & m, e);
	endtask

	// Let n edges pass, then sample settled outputs
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse_fin();
		@(posedge clk);
		fg_fin <= 1'b1;
		@(posedge clk);
		fg_fin <= 1'b0;
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(`ACC_IDX_EN, 32'hffff_ffff, 32'h01);
		rd(`ACC_IDX_CFG0, 32'hffff_ffff, 32'h01);
		rd(`ACC_IDX_CFG1, 32'hffff_ffff, 32'h01);
		rd(`ACC_IDX_AVG, 32'hffff_ffff, 32'h61);
		rd(`ACC_IDX_PIN, 32'hffff_ffff, 32'h00);
		rd(`ACC_IDX_TRIG, 32'hffff_ffff, 32'h01);
		w(2);
		chk(n_clr, 1);
		chk(n_fgs, 1);
		chk({fos, bos, oref, osavg, linavg}, {3'b000, 3'h6, 3'h1});
		rd(`ACC_IDX_STAT, 32'h1f, 32'h08);
		wr(`ACC_IDX_STAT, 8'hff);
		rd(`ACC_IDX_STAT, 32'hffff_ffff, 32'h08);
		// Unmapped place and a write with byte lane 0 off both leave things untouched
		wr(8'h70, 8'h5a);
		rd(8'h70, 32'hffff_ffff, 32'h00);
		xfer(1'b1, `ACC_IDX_AVG, 8'h00, 4'he, q);
		rd(`ACC_IDX_AVG, 32'hffff_ffff, 32'h61);
		// Foreground finishes with background off
		pulse_fin();
		w(3);
		rd(`ACC_IDX_STAT, 32'h1f, 32'h13);
		// Reconfigure while held, then restart with background on
		wr(`ACC_IDX_EN, 8'h00);
		wr(`ACC_IDX_CFG0, 8'h0f);
		wr(`ACC_IDX_CFG1, 8'h05);
		wr(`ACC_IDX_AVG, 8'h73);
		wr(`ACC_IDX_EN, 8'h01);
		w(5);
		chk({fos, bos, oref, osavg, linavg}, {3'b111, 3'h7, 3'h3});
		wr(`ACC_IDX_AVG, 8'h12);
		w(3);
		chk({osavg, linavg}, {3'h7, 3'h3});
		rd(`ACC_IDX_AVG, 32'hffff_ffff, 32'h12);
		pulse_fin();
		w(4);
		rd(`ACC_IDX_STAT, 32'h1f, 32'h0d);
		chk(bg_run, 1);
		// Status pin routing, with done and stopped differing
		@(posedge clk);
		alarm <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			wr(`ACC_IDX_PIN, 8'(s << 1));
			w(3);
			chk(stat_pin, (s == 0 || s == 2) ? 1 : 0);
		end
		@(posedge clk);
		alarm <= 1'b0;
		// Halt through the software trigger, then resume
		bg_halt <= 1'b1;
		wr(`ACC_IDX_TRIG, 8'h00);
		w(4);
		chk(bg_run, 0);
		rd(`ACC_IDX_STAT, 32'h02, 32'h02);
		wr(`ACC_IDX_TRIG, 8'h01);
		w(4);
		rd(`ACC_IDX_STAT, 32'h02, 32'h00);
		// Hardware trigger pin takes over; software bit stays high
		wr(`ACC_IDX_PIN, 8'h01);
		w(4);
		chk(bg_run, 0);
		@(posedge clk);
		hw_trig <= 1'b1;
		w(4);
		chk(bg_run, 1);
		@(posedge clk);
		hw_trig <= 1'b0;
		bg_halt <= 1'b0;
		// Skipped foreground: values still cleared, no start, flags set
		wr(`ACC_IDX_EN, 8'h00);
		wr(`ACC_IDX_CFG0, 8'h00);
		wr(`ACC_IDX_EN, 8'h01);
		w(5);
		// Three runs so far: after reset, after reconfiguration, and this skip
		chk(n_clr, 3);
		chk(n_fgs, 2);
		chk({fos, bos}, 2'b00);
		rd(`ACC_IDX_STAT, 32'h1f, 32'h13);
		wrap_up();
	end
endmodule
`default_nettype wire
